// >>> wbs_pkg.sv
// shared constants and types of the word access bus sequencer
package wbs_pkg;
    localparam int          ADDR_W        = 20;
    localparam logic [19:0] ADDR_MAX      = 20'hF_FFFF;
    localparam logic [19:0] INTR_LO       = 20'h0_0000;
    localparam logic [19:0] INTR_HI       = 20'h0_007F;
    localparam logic [19:0] RESET_LO      = 20'hF_FFF0;
    localparam logic [19:0] RESET_HI      = 20'hF_FFFF;
    localparam logic [15:0] DATA_RST      = 16'h0000;
    localparam logic [19:0] ADDR_RST      = 20'h0_0000;
    localparam logic [1:0]  LANE_LO       = 2'b01;
    localparam logic [1:0]  LANE_HI       = 2'b10;
    localparam logic [1:0]  LANE_BOTH     = 2'b11;
    localparam logic [1:0]  LANE_NONE     = 2'b00;

    typedef enum logic [1:0]
    {
        WBS_IDLE  = 2'b00,
        WBS_FIRST = 2'b01,
        WBS_SECND = 2'b10
    } wbs_state_type;
endpackage : wbs_pkg

// >>> wbs_lane.sv
// byte lane steering for one bus cycle
`timescale 1ns/1ps
module wbs_lane
    import wbs_pkg::*;
(
    input  wire logic        wide_bus,
    input  wire logic        word_cyc,
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  byte_out,
    input  wire logic [15:0] word_out,
    output logic      [1:0]  lanes,
    output logic      [15:0] bus_data
);
    // narrow bus always uses the low lane; wide bus uses both lanes for a word cycle, else picks by address bit 0
    always_comb
    begin
        if (!wide_bus)
        begin
            lanes    = LANE_LO;
            bus_data = {8'h00, byte_out};
        end
        else if (word_cyc)
        begin
            lanes    = LANE_BOTH;
            bus_data = word_out;
        end
        else if (addr[0])
        begin
            lanes    = LANE_HI;
            bus_data = {byte_out, 8'h00};
        end
        else
        begin
            lanes    = LANE_LO;
            bus_data = {8'h00, byte_out};
        end
    end
endmodule : wbs_lane

// >>> wbs_sequencer.sv
// request to bus cycle sequencer for both bus widths
`timescale 1ns/1ps
// How it works
// - wide bus moves bytes or whole words
// - even word on wide bus, one cycle
// - odd word on wide bus, two byte cycles
// - split word returns same value as aligned
// - wide prefetch fetches words at even addresses
// - odd jump target: first fetch one byte
// - narrow bus cycles are always one byte
// - narrow bus words always take two cycles
// - narrow prefetch fetches one byte each
// - every cycle presents a 20-bit address
module wbs_sequencer
    import wbs_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        WIDE_BUS,
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic        REQ_WRITE,
    input  wire logic        REQ_WORD,
    input  wire logic        REQ_FETCH,
    input  wire logic        REQ_JUMP,
    input  wire logic [19:0] REQ_ADDR,
    input  wire logic [15:0] REQ_WDATA,
    output logic             RSP_VALID,
    output logic      [15:0] RSP_RDATA,
    output logic             RSP_WORD,
    output logic             BUS_REQ,
    input  wire logic        BUS_ACK,
    output logic             BUS_WRITE,
    output logic      [19:0] BUS_ADDR,
    output logic      [1:0]  BUS_LANES,
    output logic      [15:0] BUS_WDATA,
    input  wire logic [15:0] BUS_RDATA,
    output logic             IN_INTR_AREA,
    output logic             IN_RESET_AREA
);
    ////////////////////////////////////////////////////////////////////////////
    wbs_state_type state_reg;
    logic          write_reg;
    logic          word_reg;
    logic          split_reg;
    logic          fetch_reg;
    logic [19:0]   addr_reg;
    logic [15:0]   wdata_reg;
    logic [7:0]    low_reg;
    logic [19:0]   pf_next_reg;
    logic          cyc_word;
    logic [7:0]    byte_out;
    logic [1:0]    lanes;
    logic [15:0]   bus_data;
    logic [19:0]   addr_next;
    logic          take;
    logic          done;
    logic [7:0]    rbyte;
    logic          bus_live_reg;

    ////////////////////////////////////////////////////////////////////////////
    // one request in flight; ready only while idle
    assign REQ_READY = (state_reg == WBS_IDLE);
    assign take      = REQ_VALID && REQ_READY;
    assign done      = BUS_REQ && BUS_ACK;
    assign BUS_REQ   = (state_reg != WBS_IDLE);
    assign addr_next = addr_reg + 20'h0_0001;   // wraps at the megabyte top

    // word cycle only for unsplit words on the wide bus
    assign cyc_word = word_reg && !split_reg;
    assign byte_out = (state_reg == WBS_SECND) ? wdata_reg[15:8] : wdata_reg[7:0];

    // pick the byte from the lane the current address lives on
    assign rbyte = (WIDE_BUS && addr_reg[0]) ? BUS_RDATA[15:8] : BUS_RDATA[7:0];

    wbs_lane u_lane
    (
        .wide_bus (WIDE_BUS),
        .word_cyc (cyc_word),
        .addr     (addr_reg),
        .byte_out (byte_out),
        .word_out (wdata_reg),
        .lanes    (lanes),
        .bus_data (bus_data)
    );

    // bus cycle outputs held stable until acknowledge
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BUS_ADDR  <= ADDR_RST;
            BUS_WRITE <= 1'b0;
            BUS_LANES <= LANE_NONE;
            BUS_WDATA <= DATA_RST;
            bus_live_reg <= 1'b0;
        end
        else
        begin
            BUS_ADDR  <= (state_reg == WBS_IDLE) ? ADDR_RST : addr_reg;
            BUS_WRITE <= (state_reg != WBS_IDLE) && write_reg;
            BUS_LANES <= (state_reg == WBS_IDLE) ? LANE_NONE : lanes;
            BUS_WDATA <= (state_reg == WBS_IDLE) ? DATA_RST : bus_data;
            bus_live_reg <= (state_reg != WBS_IDLE);    // registered outputs now show a live cycle
        end
    end

    // sequencing: a fetch word is demoted to a byte when odd
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg <= WBS_IDLE;
            write_reg <= 1'b0;
            word_reg  <= 1'b0;
            split_reg <= 1'b0;
            fetch_reg <= 1'b0;
            addr_reg  <= ADDR_RST;
            wdata_reg <= DATA_RST;
        end
        else
        begin
            unique case (state_reg)
                WBS_IDLE:
                begin
                    if (take)
                    begin
                        state_reg <= WBS_FIRST;
                        write_reg <= REQ_WRITE && !REQ_FETCH;
                        fetch_reg <= REQ_FETCH;
                        addr_reg  <= REQ_ADDR;
                        wdata_reg <= REQ_WDATA;
                        if (REQ_FETCH)
                        begin
                            // odd target fetches a byte; narrow bus always bytes
                            word_reg  <= WIDE_BUS && !REQ_ADDR[0];
                            split_reg <= 1'b0;
                        end
                        else
                        begin
                            word_reg  <= REQ_WORD;
                            split_reg <= REQ_WORD && (!WIDE_BUS || REQ_ADDR[0]);
                        end
                    end
                end
                WBS_FIRST:
                begin
                    if (done)
                    begin
                        if (split_reg)
                        begin
                            state_reg <= WBS_SECND;
                            addr_reg  <= addr_next;        // high byte next
                        end
                        else
                        begin
                            state_reg <= WBS_IDLE;
                        end
                    end
                end
                WBS_SECND:
                begin
                    if (done)
                    begin
                        state_reg <= WBS_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= WBS_IDLE;
                end
            endcase
        end
    end

    // prefetch pointer: advances by two after a word fetch, by one after a byte fetch
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pf_next_reg <= ADDR_RST;
        end
        else if (done && fetch_reg)
        begin
            pf_next_reg <= cyc_word ? (addr_reg + 20'h0_0002) : addr_next;
        end
    end

    // read assembly: low byte kept, high byte joined on the second cycle
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            low_reg   <= 8'h00;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= DATA_RST;
            RSP_WORD  <= 1'b0;
        end
        else
        begin
            RSP_VALID <= 1'b0;
            if (done && state_reg == WBS_FIRST)
            begin
                low_reg <= rbyte;
                if (!split_reg)
                begin
                    RSP_VALID <= 1'b1;
                    RSP_WORD  <= cyc_word;
                    RSP_RDATA <= cyc_word ? BUS_RDATA : {8'h00, rbyte};
                end
            end
            else if (done && state_reg == WBS_SECND)
            begin
                RSP_VALID <= 1'b1;
                RSP_WORD  <= 1'b1;
                RSP_RDATA <= {rbyte, low_reg};     // same value as aligned
            end
        end
    end

    // reserved regions flagged; keeping them free is the system's job
    // gated until the address register is live, else the idle address 0 flags every first cycle
    assign IN_INTR_AREA  = BUS_REQ && bus_live_reg && (BUS_ADDR <= INTR_HI);
    assign IN_RESET_AREA = BUS_REQ && bus_live_reg && (BUS_ADDR >= RESET_LO);

    ////////////////////////////////////////////////////////////////////////////
    // narrow bus never drives both lanes
    narrow_lane_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (BUS_REQ && $past(BUS_REQ) && !WIDE_BUS) |-> (BUS_LANES == LANE_LO))
        else $error("narrow bus cycle not a single byte");

    // odd word is split then second cycle at address plus one
    split_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == WBS_FIRST && done && split_reg) |=> ##1 (BUS_ADDR == $past(addr_reg, 2) + 20'h0_0001))
        else $error("second byte address wrong");

    // even word on wide bus is one both-lane cycle
    even_word_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (take && WIDE_BUS && REQ_WORD && !REQ_FETCH && !REQ_ADDR[0]) |=> ##1 (BUS_LANES == LANE_BOTH))
        else $error("even word not a word cycle");

    // odd byte cycle uses the high lane
    odd_lane_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (BUS_REQ && WIDE_BUS && BUS_LANES != LANE_BOTH && $past(BUS_REQ)) |->
        (BUS_LANES == (BUS_ADDR[0] ? LANE_HI : LANE_LO)))
        else $error("byte lane does not match address");

    // split word response joins both bytes
    join_word_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == WBS_SECND && done) |=> (RSP_VALID && RSP_WORD && RSP_RDATA[7:0] == $past(low_reg)))
        else $error("split word response malformed");

    // odd fetch is a byte cycle
    odd_fetch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (take && REQ_FETCH && REQ_ADDR[0]) |=> !word_reg && !split_reg)
        else $error("odd fetch not a byte");

    // narrow word always splits
    narrow_split_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (take && !WIDE_BUS && REQ_WORD && !REQ_FETCH) |=> split_reg)
        else $error("narrow word not split");

    // word fetches only at even addresses
    fetch_even_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (BUS_REQ && fetch_reg && BUS_LANES == LANE_BOTH) |-> !BUS_ADDR[0])
        else $error("word fetch at odd address");

    // narrow fetch is one byte
    narrow_fetch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (take && !WIDE_BUS && REQ_FETCH) |=> !word_reg)
        else $error("narrow fetch not a byte");

    // split second cycle follows first without gap
    back_to_back_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == WBS_FIRST && done && split_reg) |=> (state_reg == WBS_SECND && BUS_REQ))
        else $error("split cycles not back to back");

    // byte fetch at an odd target leaves the pointer on the next even address
    fetch_next_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (done && fetch_reg && addr_reg[0]) |=> (!pf_next_reg[0] && pf_next_reg == $past(addr_reg) + 20'h0_0001))
        else $error("next fetch address not even");
endmodule : wbs_sequencer

// >>> wbs_mem_model.sv
// memory system partner model for the sequencer bus side
`timescale 1ns/1ps
module wbs_mem_model
    import wbs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        wide,
    input  wire logic [3:0]  delay,
    input  wire logic        req,
    output logic             ack,
    input  wire logic        wr,
    input  wire logic [19:0] addr,
    input  wire logic [1:0]  lanes,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);
    logic [7:0]  mem [logic [19:0]];
    logic [3:0]  wait_reg = 4'h0;
    logic [15:0] last_reg = 16'h0000;
    logic [19:0] base;
    initial ack = 1'b0;

    // unwritten bytes read back a pattern derived from the address
    function automatic logic [7:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ 8'hC3;
    endfunction : rd

    assign base = wide ? {addr[19:1], 1'b0} : addr;
    ////////////////////////////////////////
    // ack never in the first request cycle, since address lands a cycle late
    always @(posedge clk)
    begin
        ack      <= req && !ack && (wait_reg >= delay);
        wait_reg <= (req && !ack) ? wait_reg + 4'h1 : 4'h0;
        if (req && ack && wr && (!wide || lanes[0]))
            mem[base] = wdata[7:0];
        if (req && ack && wr && wide && lanes[1])
            mem[base + 20'h1] = wdata[15:8];
        if (req && ack)
            last_reg <= rdata;
    end
    // idle lanes show the inverse of the last value, not a stale copy
    always @*
    begin
        rdata = ~last_reg;
        if (req && ack && !wr && (!wide || lanes[0]))
            rdata[7:0] = rd(base);
        if (req && ack && !wr && wide && lanes[1])
            rdata[15:8] = rd(base + 20'h1);
    end
endmodule : wbs_mem_model

// >>> wbs_sequencer_tb.sv
// self-checking bench for the word access bus sequencer
`timescale 1ns/1ps
module wbs_sequencer_tb
    import wbs_pkg::*;
;
    logic        CORE_CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        WIDE_BUS = 1'b1;
    logic        REQ_VALID, REQ_READY, REQ_WRITE, REQ_WORD, REQ_FETCH, REQ_JUMP;
    logic [19:0] REQ_ADDR, BUS_ADDR;
    logic [15:0] REQ_WDATA, RSP_RDATA, BUS_WDATA, BUS_RDATA;
    logic        RSP_VALID, RSP_WORD, BUS_REQ, BUS_ACK, BUS_WRITE, IN_INTR_AREA, IN_RESET_AREA;
    logic [1:0]  BUS_LANES;
    logic [3:0]  ack_dly = 4'h0;
    logic [21:0] cyc_q [$];
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          hit_intr = 0;
    int          hit_rst = 0;

    wbs_sequencer dut_u (.CORE_CLK, .RST_N, .WIDE_BUS, .REQ_VALID, .REQ_READY, .REQ_WRITE, .REQ_WORD,
        .REQ_FETCH, .REQ_JUMP, .REQ_ADDR, .REQ_WDATA, .RSP_VALID, .RSP_RDATA, .RSP_WORD, .BUS_REQ,
        .BUS_ACK, .BUS_WRITE, .BUS_ADDR, .BUS_LANES, .BUS_WDATA, .BUS_RDATA, .IN_INTR_AREA, .IN_RESET_AREA);
    wbs_mem_model mem_u (.clk(CORE_CLK), .wide(WIDE_BUS), .delay(ack_dly), .req(BUS_REQ), .ack(BUS_ACK),
        .wr(BUS_WRITE), .addr(BUS_ADDR), .lanes(BUS_LANES), .wdata(BUS_WDATA), .rdata(BUS_RDATA));

    always #2 CORE_CLK = ~CORE_CLK;
    // log every completed bus cycle as address and lanes
    // and count every cycle that a reserved-area flag stands
    always @(posedge CORE_CLK)
    begin
        if (BUS_REQ && BUS_ACK)
            cyc_q.push_back({BUS_ADDR, BUS_LANES});
        if (IN_INTR_AREA === 1'b1)
            hit_intr++;
        if (IN_RESET_AREA === 1'b1)
            hit_rst++;
    end
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one request, then judge cycle count, order, lanes and returned value
    task automatic access(input logic wr, wd, fe, input logic [19:0] a, input logic [15:0] d,
                          input int n, input logic [1:0] l1, l2, input logic [15:0] exp);
        int   i;
        int   i0;
        int   r0;
        logic w;
        cyc_q.delete();
        i0 = hit_intr;
        r0 = hit_rst;
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b1;
        REQ_WRITE <= wr;
        REQ_WORD  <= wd;
        REQ_FETCH <= fe;
        REQ_JUMP  <= fe && a[0];
        REQ_ADDR  <= a;
        REQ_WDATA <= d;
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        i = 0;
        do
        begin
            @(negedge CORE_CLK);
            i++;
        end
        while (RSP_VALID !== 1'b1 && i < 80);
        w = (wd && !fe) || (fe && WIDE_BUS && !a[0]);
        chk("rsp_valid", 22'h00_0001, {21'h0, RSP_VALID});
        chk("cycles", 22'(n), 22'(cyc_q.size()));
        chk("cycle0", {a, l1}, cyc_q[0]);
        if (n == 2)
            chk("cycle1", {a + 20'h1, l2}, cyc_q[1]);
        chk("rsp_word", {21'h0, w}, {21'h0, RSP_WORD});
        if (!wr)
            chk("rdata", {6'h00, exp}, {6'h00, RSP_RDATA});
        chk("intr_area", {21'h0, a <= INTR_HI}, {21'h0, hit_intr != i0});
        chk("reset_area", {21'h0, a >= RESET_LO}, {21'h0, hit_rst != r0});
    endtask : access
    ////////////////////////////////////////
    // only vector reads and reset fetches touch the reserved areas
    task automatic wide_operands;
        access(1, 1, 0, 20'h0_1000, 16'hA55A, 1, LANE_BOTH, LANE_NONE, 16'h0000);
        access(0, 1, 0, 20'h0_1000, 16'h0000, 1, LANE_BOTH, LANE_NONE, 16'hA55A);
        access(1, 1, 0, 20'h0_1235, 16'hBEEF, 2, LANE_HI, LANE_LO, 16'h0000);
        access(0, 1, 0, 20'h0_1235, 16'h0000, 2, LANE_HI, LANE_LO, 16'hBEEF);
        access(0, 0, 0, 20'h0_1236, 16'h0000, 1, LANE_LO, LANE_NONE, 16'h00BE);
    endtask : wide_operands

    task automatic wide_fetches;
        access(0, 0, 1, 20'h0_2000, 16'h0000, 1, LANE_BOTH, LANE_NONE, 16'hC2C3);
        access(0, 0, 1, 20'h0_2001, 16'h0000, 1, LANE_HI, LANE_NONE, 16'h00C2);
        access(0, 0, 1, 20'h0_2002, 16'h0000, 1, LANE_BOTH, LANE_NONE, 16'hC0C1);
        access(0, 0, 1, 20'hF_FFF0, 16'h0000, 1, LANE_BOTH, LANE_NONE, 16'h3233);
        access(0, 1, 0, 20'h0_0010, 16'h0000, 1, LANE_BOTH, LANE_NONE, 16'hD2D3);
    endtask : wide_fetches

    // narrow bus with a slow memory answering late, then one wide read back with no delay
    task automatic narrow_ops;
        @(posedge CORE_CLK);
        WIDE_BUS <= 1'b0;
        ack_dly  <= 4'h3;
        access(0, 1, 0, 20'h0_1000, 16'h0000, 2, LANE_LO, LANE_LO, 16'hA55A);
        access(0, 1, 0, 20'h0_1235, 16'h0000, 2, LANE_LO, LANE_LO, 16'hBEEF);
        access(1, 1, 0, 20'h0_3000, 16'h1234, 2, LANE_LO, LANE_LO, 16'h0000);
        access(1, 0, 0, 20'h0_1237, 16'h0077, 1, LANE_LO, LANE_NONE, 16'h0000);
        access(0, 0, 1, 20'h0_1237, 16'h0000, 1, LANE_LO, LANE_NONE, 16'h0077);
        access(0, 0, 1, 20'h0_2002, 16'h0000, 1, LANE_LO, LANE_NONE, 16'h00C1);
        @(posedge CORE_CLK);
        WIDE_BUS <= 1'b1;
        ack_dly  <= 4'h0;
        access(0, 1, 0, 20'h0_3000, 16'h0000, 1, LANE_BOTH, LANE_NONE, 16'h1234);
    endtask : narrow_ops

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    initial
    begin
        {REQ_VALID, REQ_WRITE, REQ_WORD, REQ_FETCH, REQ_JUMP} = 5'b00000;
        REQ_ADDR  = 20'h0_0000;
        REQ_WDATA = 16'h0000;
        repeat (16) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        wide_operands();
        wide_fetches();
        narrow_ops();
        tally_and_finish();
    end
    // a whole run needs well under 2000 cycles
    initial
    begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : wbs_sequencer_tb
